// file: a429_pkg.sv
package a429_pkg;
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned HS_RATE_BPS = 100_000;
  localparam int unsigned LS_RATE_BPS = 12_500;
  localparam logic [15:0] HS_BIT_CYC  = 16'(CLK_HZ / HS_RATE_BPS);
  localparam logic [15:0] LS_BIT_CYC  = 16'(CLK_HZ / LS_RATE_BPS);
  localparam int unsigned GAP_BITS    = 2;
  localparam int unsigned WORD_BITS   = 32;
  localparam int unsigned HIT_DEPTH   = 8;

  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] MATCH_OFS  = 8'h04;
  localparam logic [7:0] DCFG_OFS   = 8'h08;
  localparam logic [7:0] DMIN_OFS   = 8'h0C;
  localparam logic [7:0] DMAX_OFS   = 8'h10;
  localparam logic [7:0] DCARE_OFS  = 8'h14;
  localparam logic [7:0] TMIN_OFS   = 8'h18;
  localparam logic [7:0] TMAX_OFS   = 8'h1C;
  localparam logic [7:0] UBIT_OFS   = 8'h20;
  localparam logic [7:0] STAT_OFS   = 8'h24;
  localparam logic [7:0] LWORD_OFS  = 8'h28;
  localparam logic [7:0] TSTA_OFS   = 8'h2C;
  localparam logic [7:0] TSTO_OFS   = 8'h30;
  localparam logic [7:0] HIT_OFS    = 8'h40;

  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] DCARE_RST = 32'h0007_FFFF;
  localparam logic [31:0] UBIT_RST  = 32'h0000_01F4;
  localparam logic [2:0]  LAYOUT_CODE_THREE = 3'h3;

  typedef enum logic [2:0] {
    TRIG_WORD, TRIG_ERROR, TRIG_LABEL, TRIG_LABEL_DATA, TRIG_TRANSMISSION
  } trig_type_e;

  typedef enum logic [2:0] {
    CMP_EQ, CMP_NE, CMP_LT, CMP_LE, CMP_GT, CMP_GE, CMP_IN, CMP_OUT
  } cmp_e;

  typedef enum logic [1:0] {
    RATE_HIGH, RATE_LOW, RATE_USER
  } rate_e;

  typedef struct packed {
    logic        parity;
    logic [1:0]  ssm;
    logic [18:0] data;
    logic [1:0]  sdi;
    logic [7:0]  label;
  } word_s;

  typedef struct packed {
    logic        coding;
    logic        gap;
    logic        parity;
  } err_s;

  typedef struct packed {
    word_s       word;
    err_s        err;
    logic [31:0] start_ts;
    logic [31:0] stop_ts;
  } result_s;
endpackage

// file: a429_trigger_search.sv
module a429_trigger_search (
  input  wire logic                  ref_clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  line_hi_i,
  input  wire logic                  line_lo_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [7:0]            paddr_i,
  input  wire logic [31:0]           pwdata_i,
  input  wire logic [3:0]            pstrb_i,
  output logic                       pready_o,
  output logic [31:0]                prdata_o,
  output logic                       pslverr_o,
  output logic                       trigger_o,
  output logic                       word_valid_o,
  output a429_pkg::result_s          word_result_o
);
  import a429_pkg::*;

  typedef enum logic {RX_IDLE, RX_WORD} rx_e;

  // Pin synchronisers
  logic [1:0] hi_sync_q, lo_sync_q;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hi_sync_q <= 2'b00;
      lo_sync_q <= 2'b00;
    end else begin
      hi_sync_q <= {hi_sync_q[0], line_hi_i};
      lo_sync_q <= {lo_sync_q[0], line_lo_i};
    end
  end
  wire hi_s = hi_sync_q[1];
  wire lo_s = lo_sync_q[1];

  // Software registers
  logic [31:0] ctrl_q, match_q, dcfg_q, dmin_q, dmax_q, dcare_q;
  logic [31:0] tmin_q, tmax_q, ubit_q;
  logic [31:0] ctrl_d, match_d, dcfg_d, dmin_d, dmax_d, dcare_d;
  logic [31:0] tmin_d, tmax_d, ubit_d;
  logic        pready_d, pslverr_d;
  logic [31:0] prdata_d;

  // Receiver and result state
  rx_e         rx_q, rx_d;
  logic [5:0]  bit_cnt_q, bit_cnt_d;
  logic [31:0] shift_q, shift_d;
  logic [15:0] idle_q, idle_d;
  logic        pulse_q, pulse_d;
  logic        coding_q, coding_d;
  logic [31:0] now_q, now_d;
  logic [31:0] wstart_q, wstart_d;
  logic [31:0] trig_ts_q, trig_ts_d;
  logic [31:0] last_tx_q, last_tx_d;
  logic        seen_tx_q, seen_tx_d;
  logic        trig_q, trig_d;
  logic        wvalid_q, wvalid_d;
  result_s     res_q, res_d;
  logic [31:0] hit_word_q [HIT_DEPTH];
  logic [31:0] hit_ts_q   [HIT_DEPTH];
  logic [31:0] hit_word_d [HIT_DEPTH];
  logic [31:0] hit_ts_d   [HIT_DEPTH];
  logic [3:0]  hit_cnt_q, hit_cnt_d;

  trig_type_e  ttype;
  cmp_e        dcond, tcond;
  logic [15:0] bit_cyc, gap_lim;

  always_comb begin
    ttype = trig_type_e'(ctrl_q[2:0]);
    dcond = cmp_e'(dcfg_q[12:10]);
    tcond = cmp_e'(dcfg_q[15:13]);
    case (rate_e'(ctrl_q[9:8]))
      RATE_HIGH: bit_cyc = HS_BIT_CYC;
      RATE_LOW:  bit_cyc = LS_BIT_CYC;
      default:   bit_cyc = ubit_q[15:0];
    endcase
    gap_lim = 16'(bit_cyc * 16'(GAP_BITS));
  end

  function automatic logic cmp_ok(cmp_e c, logic [31:0] v,
                                  logic [31:0] mn, logic [31:0] mx);
    case (c)
      CMP_EQ:  cmp_ok = (v == mn);
      CMP_NE:  cmp_ok = (v != mn);
      CMP_LT:  cmp_ok = (v < mn);
      CMP_LE:  cmp_ok = (v <= mn);
      CMP_GT:  cmp_ok = (v > mn);
      CMP_GE:  cmp_ok = (v >= mn);
      CMP_IN:  cmp_ok = (v >= mn) && (v <= mx);
      default: cmp_ok = (v < mn) || (v > mx);
    endcase
  endfunction

  function automatic logic [31:0] strb_wr(logic [31:0] old,
                                          logic [31:0] wd,
                                          logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    strb_wr = r;
  endfunction

  // Word evaluation on the assembled bits
  word_s       w;
  err_s        e;
  logic [31:0] dval, dmask, care, interval;
  logic        lbl_ok, ld_ok, gap_abort;
  always_comb begin
    // Layout code three and the default share one field order
    w = word_s'(shift_d);
    e.parity = ctrl_q[5] && !(^shift_d);
    // Taken ahead of the end-of-word clear of the coding flag
    e.coding = ctrl_q[7] && (coding_q || (hi_s && lo_s));
    e.gap = gap_abort && ctrl_q[6];
    dmask = (dcfg_q[9:5] >= 5'd19 || dcfg_q[9:5] == 5'd0) ?
            32'h0007_FFFF : ((32'h0000_0001 << dcfg_q[9:5]) - 32'h1);
    dval = (32'(w.data) >> dcfg_q[4:0]) & dmask;
    care = dcare_q & dmask;
    lbl_ok = (w.label == match_q[7:0]);
    ld_ok = lbl_ok && (w.ssm == match_q[9:8])
            && (w.sdi == match_q[11:10])
            && cmp_ok(dcond, dval & care, dmin_q & care, dmax_q & care);
    // Start to start, so word length does not skew the interval
    interval = wstart_q - last_tx_q;
  end

  always_comb begin
    ctrl_d = ctrl_q;
    match_d = match_q;
    dcfg_d = dcfg_q;
    dmin_d = dmin_q;
    dmax_d = dmax_q;
    dcare_d = dcare_q;
    tmin_d = tmin_q;
    tmax_d = tmax_q;
    ubit_d = ubit_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_o;
    if (psel_i && !penable_i && !pready_o) begin
      pready_d = 1'b1;
      prdata_d = 32'h0000_0000;
      if (paddr_i >= HIT_OFS) begin
        if (paddr_i[2]) begin
          prdata_d = hit_ts_q[paddr_i[5:3]];
        end else begin
          prdata_d = hit_word_q[paddr_i[5:3]];
        end
        pslverr_d = pwrite_i || paddr_i[7] || paddr_i[1:0] != 2'b00;
      end else begin
        case (paddr_i)
          CTRL_OFS:  prdata_d = ctrl_q;
          MATCH_OFS: prdata_d = match_q;
          DCFG_OFS:  prdata_d = dcfg_q;
          DMIN_OFS:  prdata_d = dmin_q;
          DMAX_OFS:  prdata_d = dmax_q;
          DCARE_OFS: prdata_d = dcare_q;
          TMIN_OFS:  prdata_d = tmin_q;
          TMAX_OFS:  prdata_d = tmax_q;
          UBIT_OFS:  prdata_d = ubit_q;
          STAT_OFS:  prdata_d = {24'h0, hit_cnt_q, 1'b0, res_q.err};
          LWORD_OFS: prdata_d = res_q.word;
          TSTA_OFS:  prdata_d = res_q.start_ts;
          TSTO_OFS:  prdata_d = res_q.stop_ts;
          default:   pslverr_d = 1'b1;
        endcase
        if (pwrite_i) begin
          case (paddr_i)
            CTRL_OFS:  ctrl_d = strb_wr(ctrl_q, pwdata_i, pstrb_i);
            MATCH_OFS: match_d = strb_wr(match_q, pwdata_i, pstrb_i);
            DCFG_OFS:  dcfg_d = strb_wr(dcfg_q, pwdata_i, pstrb_i);
            DMIN_OFS:  dmin_d = strb_wr(dmin_q, pwdata_i, pstrb_i);
            DMAX_OFS:  dmax_d = strb_wr(dmax_q, pwdata_i, pstrb_i);
            DCARE_OFS: dcare_d = strb_wr(dcare_q, pwdata_i, pstrb_i);
            TMIN_OFS:  tmin_d = strb_wr(tmin_q, pwdata_i, pstrb_i);
            TMAX_OFS:  tmax_d = strb_wr(tmax_q, pwdata_i, pstrb_i);
            UBIT_OFS:  ubit_d = strb_wr(ubit_q, pwdata_i, pstrb_i);
            default:   pslverr_d = 1'b1;
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q <= CTRL_RST;
      match_q <= 32'h0000_0000;
      dcfg_q <= 32'h0000_0000;
      dmin_q <= 32'h0000_0000;
      dmax_q <= 32'h0000_0000;
      dcare_q <= DCARE_RST;
      tmin_q <= 32'h0000_0000;
      tmax_q <= 32'h0000_0000;
      ubit_q <= UBIT_RST;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      match_q <= match_d;
      dcfg_q <= dcfg_d;
      dmin_q <= dmin_d;
      dmax_q <= dmax_d;
      dcare_q <= dcare_d;
      tmin_q <= tmin_d;
      tmax_q <= tmax_d;
      ubit_q <= ubit_d;
      pready_o <= pready_d;
      pslverr_o <= pslverr_d;
      prdata_o <= prdata_d;
    end
  end

  // Receiver, trigger and search
  logic pulse_rise, hit, fire_start, tx_ok;
  always_comb begin
    rx_d = rx_q;
    bit_cnt_d = bit_cnt_q;
    shift_d = shift_q;
    idle_d = idle_q;
    coding_d = coding_q;
    now_d = now_q + 32'h1;
    wstart_d = wstart_q;
    trig_ts_d = trig_ts_q;
    last_tx_d = last_tx_q;
    seen_tx_d = seen_tx_q;
    res_d = res_q;
    hit_word_d = hit_word_q;
    hit_ts_d = hit_ts_q;
    hit_cnt_d = hit_cnt_q;
    pulse_d = hi_s || lo_s;
    pulse_rise = pulse_d && !pulse_q;
    hit = 1'b0;
    fire_start = 1'b0;
    gap_abort = 1'b0;
    tx_ok = 1'b0;
    wvalid_d = 1'b0;
    // Restart the record whenever search is switched on
    if (ctrl_d[4] && !ctrl_q[4]) begin
      hit_cnt_d = 4'h0;
    end
    if (hi_s && lo_s) begin
      coding_d = 1'b1;
    end
    case (rx_q)
      RX_IDLE: begin
        idle_d = 16'h0;
        if (pulse_rise) begin
          rx_d = RX_WORD;
          bit_cnt_d = 6'd1;
          shift_d = {31'h0, hi_s};
          wstart_d = now_q;
          fire_start = (ttype == TRIG_WORD) && !ctrl_q[3];
        end
      end
      RX_WORD: begin
        idle_d = (idle_q == 16'hFFFF) ? idle_q : idle_q + 16'h1;
        if (pulse_rise) begin
          idle_d = 16'h0;
          shift_d[bit_cnt_q[4:0]] = hi_s;
          bit_cnt_d = bit_cnt_q + 6'd1;
        end else if (idle_q >= gap_lim) begin
          gap_abort = 1'b1;
        end
      end
      default: rx_d = RX_IDLE;
    endcase
    if (bit_cnt_d == 6'(WORD_BITS) || gap_abort) begin
      rx_d = RX_IDLE;
      bit_cnt_d = 6'd0;
      coding_d = 1'b0;
      wvalid_d = 1'b1;
      tx_ok = seen_tx_q && cmp_ok(tcond, interval, tmin_q, tmax_q);
      case (ttype)
        TRIG_WORD:       hit = ctrl_q[3] && !gap_abort;
        TRIG_ERROR:      hit = e.parity || e.coding || e.gap;
        TRIG_LABEL:      hit = lbl_ok && !gap_abort;
        TRIG_LABEL_DATA: hit = ld_ok && !gap_abort;
        default:         hit = ld_ok && tx_ok && !gap_abort;
      endcase
      if (ttype == TRIG_TRANSMISSION && ld_ok && !gap_abort) begin
        last_tx_d = wstart_q;
        seen_tx_d = 1'b1;
      end
    end
    if (!ctrl_q[4] && (hit || fire_start)) begin
      trig_ts_d = now_q;
    end
    if (ctrl_q[4] && hit && hit_cnt_d < 4'(HIT_DEPTH)) begin
      hit_word_d[hit_cnt_d[2:0]] = shift_d;
      hit_ts_d[hit_cnt_d[2:0]] = now_q;
      hit_cnt_d = hit_cnt_d + 4'h1;
    end
    trig_d = !ctrl_q[4] && (hit || fire_start);
    if (wvalid_d) begin
      res_d.word = word_s'(shift_d);
      res_d.err = e;
      res_d.start_ts = wstart_q - trig_ts_d;
      res_d.stop_ts = now_q - trig_ts_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_q <= RX_IDLE;
      bit_cnt_q <= 6'd0;
      shift_q <= 32'h0000_0000;
      idle_q <= 16'h0000;
      pulse_q <= 1'b0;
      coding_q <= 1'b0;
      now_q <= 32'h0000_0000;
      wstart_q <= 32'h0000_0000;
      trig_ts_q <= 32'h0000_0000;
      last_tx_q <= 32'h0000_0000;
      seen_tx_q <= 1'b0;
      trig_q <= 1'b0;
      wvalid_q <= 1'b0;
      res_q <= '0;
      hit_cnt_q <= 4'h0;
      for (int i = 0; i < HIT_DEPTH; i++) begin
        hit_word_q[i] <= 32'h0000_0000;
        hit_ts_q[i] <= 32'h0000_0000;
      end
    end else begin
      rx_q <= rx_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q <= shift_d;
      idle_q <= idle_d;
      pulse_q <= pulse_d;
      coding_q <= coding_d;
      now_q <= now_d;
      wstart_q <= wstart_d;
      trig_ts_q <= trig_ts_d;
      last_tx_q <= last_tx_d;
      seen_tx_q <= seen_tx_d;
      trig_q <= trig_d;
      wvalid_q <= wvalid_d;
      res_q <= res_d;
      hit_cnt_q <= hit_cnt_d;
      hit_word_q <= hit_word_d;
      hit_ts_q <= hit_ts_d;
    end
  end

  assign trigger_o = trig_q;
  assign word_valid_o = wvalid_q;
  assign word_result_o = res_q;
endmodule

// file: a429_trigger_search_properties.sv
module a429_trigger_search_properties (
  input wire logic              ref_clk_i,
  input wire logic              resetn_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [7:0]        paddr_i,
  input wire logic              pready_o,
  input wire logic [31:0]       prdata_o,
  input wire logic              pslverr_o,
  input wire logic              trigger_o,
  input wire logic              word_valid_o,
  input wire a429_pkg::result_s word_result_o
);
  import a429_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_setup; psel_i && !penable_i && !pready_o; endsequence
  sequence s_ro_wr;
    s_setup ##0 (pwrite_i && paddr_i >= STAT_OFS && paddr_i <= TSTO_OFS);
  endsequence
  property p_ack; s_setup |=> pready_o; endproperty
  property p_ack_pulse; pready_o |=> !pready_o; endproperty
  property p_err_ack; pslverr_o |-> pready_o; endproperty
  property p_unmapped; s_setup ##0 paddr_i[7] |=> pslverr_o; endproperty
  property p_ro; s_ro_wr |=> pslverr_o; endproperty
  property p_rd_hold; !pready_o |-> $stable(prdata_o); endproperty
  property p_trig; trigger_o |=> !trigger_o; endproperty
  property p_wv; word_valid_o |=> !word_valid_o; endproperty
  property p_res_hold; !word_valid_o |-> $stable(word_result_o); endproperty
  property p_parity;
    word_valid_o && word_result_o.err.parity && !word_result_o.err.gap
      |-> !(^word_result_o.word);
  endproperty
  a_ack: assert property (p_ack) else $error("no ready after setup");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ready too long");
  a_err_ack: assert property (p_err_ack) else $error("error without ready");
  a_unmapped: assert property (p_unmapped) else $error("no error, unmapped");
  a_ro: assert property (p_ro) else $error("no error, read-only write");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_trig: assert property (p_trig) else $error("trigger too long");
  a_wv: assert property (p_wv) else $error("valid too long");
  a_res_hold: assert property (p_res_hold) else $error("result moved");
  a_parity: assert property (p_parity) else $error("parity flag wrong");
endmodule

bind a429_trigger_search a429_trigger_search_properties i_props (
  .ref_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pready_o, .prdata_o, .pslverr_o, .trigger_o, .word_valid_o,
  .word_result_o
);

// file: a429_tx_model.sv
module a429_tx_model (
  input  wire logic ref_clk_i,
  output logic      line_hi_o,
  output logic      line_lo_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned half_cyc = 10;
  // Null level on both legs is the bus idle state, not a release
  initial begin
    line_hi_o = 1'b0;
    line_lo_o = 1'b0;
  end
  task automatic send(input logic [31:0] w, input int nb, input int bad,
                      input bit flip);
    logic [31:0] f;
    f = {(~^w[30:0]) ^ flip, w[30:0]};
    for (int i = 0; i < nb; i++) begin
      @(posedge ref_clk_i);
      line_hi_o <= f[i] | (i == bad);
      line_lo_o <= !f[i] | (i == bad);
      repeat (half_cyc) @(posedge ref_clk_i);
      line_hi_o <= 1'b0;
      line_lo_o <= 1'b0;
      repeat (half_cyc - 1) @(posedge ref_clk_i);
    end
    repeat (8 * half_cyc) @(posedge ref_clk_i);
  endtask
endmodule

// file: a429_trigger_search_tb.sv
module a429_trigger_search_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import a429_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [3:0]  pstrb_i = 4'h0;
  logic        pready_o, pslverr_o, trigger_o, word_valid_o;
  logic        line_hi_i, line_lo_i, rde, vtrig;
  logic [31:0] prdata_o, rdv;
  result_s     word_result_o, res;
  int          failures = 0;
  int          cmp_count = 0;
  int          trigs;
  int          wait_n;

  always #10 ref_clk_i = ~ref_clk_i;
  always @(negedge ref_clk_i) if (trigger_o === 1'b1) trigs++;

  a429_trigger_search i_a429_trigger_search (
    .ref_clk_i, .resetn_i, .line_hi_i, .line_lo_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .pready_o, .prdata_o,
    .pslverr_o, .trigger_o, .word_valid_o, .word_result_o
  );
  a429_tx_model i_a429_tx_model (
    .ref_clk_i, .line_hi_o(line_hi_i), .line_lo_o(line_lo_i)
  );

  task chk(input logic [31:0] s, input logic [31:0] e, input string m);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task print_verdict;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    // Wait states tolerated, though the slave answers at once
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (pready_o !== 1'b1) failures++;
    rdv = prdata_o;
    rde = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
  endtask
  function automatic logic [31:0] mk(logic [1:0] ssm, logic [18:0] dat,
                                     logic [1:0] sdi, logic [7:0] lab);
    return {1'b0, ssm, dat, sdi, lab};
  endfunction
  function automatic logic [31:0] par(logic [31:0] w);
    return {~^w[30:0], w[30:0]};
  endfunction
  task word(input logic [31:0] w, input int nb, input int bad,
            input bit flip);
    int n;
    trigs = 0;
    n = 0;
    fork
      i_a429_tx_model.send(w, nb, bad, flip);
      begin
        @(negedge ref_clk_i);
        while (word_valid_o !== 1'b1 && n < 3000) begin
          @(negedge ref_clk_i);
          n++;
        end
        res = word_result_o;
        vtrig = trigger_o;
        wait_n = n;
        if (n >= 3000) failures++;
      end
    join
  endtask

  task t_regs;
    rd(CTRL_OFS);
    chk(rdv, CTRL_RST, "ctrl reset");
    rd(DCARE_OFS);
    chk(rdv, DCARE_RST, "care reset");
    rd(UBIT_OFS);
    chk(rdv, UBIT_RST, "bit period reset");
    rd(8'h80);
    chk(rde, 1'b1, "unmapped read");
    wr(STAT_OFS, 32'h0000_0000);
    chk(rde, 1'b1, "read-only write");
    apb(1'b1, DCARE_OFS, 32'hFFFF_FF00, 4'h1);
    rd(DCARE_OFS);
    chk(rdv, 32'h0007_FF00, "byte load");
    wr(DCARE_OFS, 32'h0007_FFFF);
    wr(UBIT_OFS, 32'h0000_0014);
  endtask
  task t_word;
    wr(CTRL_OFS, 32'h0000_0208);
    word(32'h1234_5678, 32, 99, 0);
    chk(res.word, par(32'h1234_5678), "fields");
    chk(res.err, 3'h0, "status clean");
    chk(vtrig, 1'b1, "stop trigger");
    chk(trigs, 1, "one pulse");
    // First and last bit lie 31 bit periods of 20 cycles apart
    chk(res.stop_ts, 32'h0000_0000, "stop time");
    chk(res.start_ts, 32'hFFFF_FD94, "start time");
    wr(CTRL_OFS, 32'h0000_0200);
    word(32'h0ABC_DEF1, 32, 99, 0);
    chk(trigs, 1, "start pulse");
    chk(vtrig, 1'b0, "not at stop");
    chk(res.start_ts, 32'h0000_0000, "start time rel");
    chk(res.stop_ts, 32'h0000_026C, "stop time rel");
  endtask
  task t_err;
    wr(CTRL_OFS, 32'h0000_0221);
    word(32'h0000_1111, 32, 99, 0);
    chk(trigs, 0, "good parity");
    word(32'h0000_1111, 32, 99, 1);
    chk(trigs, 1, "bad parity");
    chk(res.err.parity, 1'b1, "parity flag");
    wr(CTRL_OFS, 32'h0000_0281);
    word(32'h0000_2222, 32, 99, 1);
    chk(trigs, 0, "parity masked");
    word(32'h0000_2222, 32, 5, 0);
    chk(trigs, 1, "coding");
    chk(res.err.coding, 1'b1, "coding flag");
    wr(CTRL_OFS, 32'h0000_0241);
    word(32'h0000_3333, 10, 99, 0);
    chk(trigs, 1, "gap");
    chk(res.err.gap, 1'b1, "gap flag");
    // Same spacing at high rate: the gap limit grows to two long bits
    wr(CTRL_OFS, 32'h0000_0041);
    word(32'h0000_3333, 10, 99, 0);
    chk(wait_n > int'(GAP_BITS * HS_BIT_CYC), 1'b1, "high rate gap");
  endtask
  task t_label;
    wr(MATCH_OFS, 32'h0000_065A);
    wr(CTRL_OFS, 32'h0000_0202);
    word(mk(2'h0, 19'h0_0000, 2'h0, 8'h5A), 32, 99, 0);
    chk(trigs, 1, "label hit");
    word(mk(2'h2, 19'h0_0050, 2'h1, 8'h5B), 32, 99, 0);
    chk(trigs, 0, "label miss");
    wr(DCFG_OFS, 32'h0000_1800);
    wr(DMAX_OFS, 32'h0007_FFFF);
    wr(CTRL_OFS, 32'h0000_0203);
    word(mk(2'h2, 19'h0_0050, 2'h1, 8'h5A), 32, 99, 0);
    chk(trigs, 1, "label data hit");
    word(mk(2'h1, 19'h0_0050, 2'h1, 8'h5A), 32, 99, 0);
    chk(trigs, 0, "ssm miss");
    word(mk(2'h2, 19'h0_0050, 2'h2, 8'h5A), 32, 99, 0);
    chk(trigs, 0, "sdi miss");
  endtask
  task t_data;
    logic [2:0] cd[4];
    logic       ex[4];
    cd = '{3'h0, 3'h1, 3'h6, 3'h7};
    ex = '{1'b1, 1'b0, 1'b1, 1'b0};
    wr(DMIN_OFS, 32'h0000_0005);
    wr(DMAX_OFS, 32'h0000_0009);
    for (int i = 0; i < 4; i++) begin
      wr(DCFG_OFS, 32'h0000_0084 | (32'(cd[i]) << 10));
      word(mk(2'h2, 19'h0_0050, 2'h1, 8'h5A), 32, 99, 0);
      chk(trigs, ex[i], "data compare");
    end
    wr(DCFG_OFS, 32'h0000_1884);
    word(mk(2'h2, 19'h0_00A0, 2'h1, 8'h5A), 32, 99, 0);
    chk(trigs, 0, "above range");
    wr(DCARE_OFS, 32'h0007_FFFE);
    wr(DMIN_OFS, 32'h0000_0004);
    wr(DCFG_OFS, 32'h0000_0084);
    word(mk(2'h2, 19'h0_0050, 2'h1, 8'h5A), 32, 99, 0);
    chk(trigs, 1, "care mask");
  endtask
  task t_tx;
    wr(DCFG_OFS, 32'h0000_D800);
    wr(DMIN_OFS, 32'h0000_0000);
    wr(DMAX_OFS, 32'h0007_FFFF);
    // Back-to-back words start 36 bit periods of 20 cycles apart
    wr(TMIN_OFS, 32'h0000_02BC);
    wr(TMAX_OFS, 32'h0000_02E4);
    wr(CTRL_OFS, 32'h0000_0204);
    word(mk(2'h2, 19'h0_0050, 2'h1, 8'h5A), 32, 99, 0);
    chk(trigs, 0, "first transmission");
    word(mk(2'h2, 19'h0_0050, 2'h1, 8'h5A), 32, 99, 0);
    chk(trigs, 1, "interval in range");
    wr(TMAX_OFS, 32'h0000_02C6);
    word(mk(2'h2, 19'h0_0050, 2'h1, 8'h5A), 32, 99, 0);
    chk(trigs, 0, "interval too long");
  endtask
  task t_search;
    logic [31:0] ts0;
    wr(CTRL_OFS, 32'h0000_0212);
    word(mk(2'h0, 19'h0_0001, 2'h0, 8'h5A), 32, 99, 0);
    word(mk(2'h0, 19'h0_0002, 2'h0, 8'h5B), 32, 99, 0);
    word(mk(2'h0, 19'h0_0003, 2'h0, 8'h5A), 32, 99, 0);
    chk(trigs, 0, "search silent");
    rd(STAT_OFS);
    chk(rdv[7:4], 4'h2, "hit count");
    rd(HIT_OFS);
    chk(rdv, par(mk(2'h0, 19'h0_0001, 2'h0, 8'h5A)), "hit 0");
    rd(HIT_OFS + 8'h08);
    chk(rdv, par(mk(2'h0, 19'h0_0003, 2'h0, 8'h5A)), "hit 1");
    rd(HIT_OFS + 8'h04);
    ts0 = rdv;
    rd(HIT_OFS + 8'h0C);
    // Two word spans of 720 cycles between the stored hits
    chk(rdv - ts0, 32'h0000_05A0, "hit time");
  endtask

  initial begin
    #1_000_000;
    failures++;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_regs;
    t_word;
    t_err;
    t_label;
    t_data;
    t_tx;
    t_search;
    print_verdict;
  end
endmodule
